/* logic/sadma_pkg.sv */
package sadma_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_MEM_ADDR = 4'h1;
  localparam logic [3:0] OFS_IO_LOW = 4'h2;
  localparam logic [3:0] OFS_COUNT = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MASK = 4'h5;
  localparam logic [3:0] OFS_STATE = 4'h6;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int CONTROL_W = 8;
  localparam int STATUS_W = 2;
  localparam int ST_IRQ_BIT = 0;
  localparam int ST_END_BIT = 1;
  localparam logic [15:0] IO_HIGH_ONES = 16'hFFFF;
  localparam logic [23:0] STEP_BYTE = 24'h00_0001;
  localparam logic [23:0] STEP_WORD = 24'h00_0002;
  localparam logic [23:0] MEM_ADDR_RESET = 24'h00_0000;
  localparam logic [7:0] IO_LOW_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_LAST = 16'h0001;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam int SYNC_STAGES = 2;

  // activation sources
  typedef enum logic [2:0] {
    SRC_TIMER0 = 3'h0,
    SRC_TIMER1 = 3'h1,
    SRC_TIMER2 = 3'h2,
    SRC_TIMER3 = 3'h3,
    SRC_SER_TX_EMPTY = 3'h4,
    SRC_SER_RX_FULL = 3'h5,
    SRC_EXT_REQ = 3'h6,
    SRC_NONE = 3'h7
  } sadma_src_t;

  // control register, bit 0 at the bottom
  typedef struct packed {
    sadma_src_t src;
    logic addr_dec;
    logic word_size;
    logic idle_mode;
    logic completion_irq_enable;
    logic channel_enable_bit;
  } sadma_ctrl_t;

  localparam sadma_ctrl_t CONTROL_RESET = '{src: SRC_NONE, default: 1'b0};

  // one bus cycle request towards the system bus
  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } sadma_bus_cmd_t;

  localparam sadma_bus_cmd_t BUS_IDLE = '0;

endpackage : sadma_pkg

/* logic/sadma_req_sel.sv */
module sadma_req_sel #(
  parameter int STAGES = sadma_pkg::SYNC_STAGES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // source selection and acceptance
  input wire sadma_pkg::sadma_src_t i_src,
  input wire logic i_take,
  // request sources
  input wire logic [3:0] i_timer_match,
  input wire logic i_ser_tx_empty,
  input wire logic i_ser_rx_full,
  input wire logic i_ext_req_n,
  // pending request
  output logic o_pending
);

  if (STAGES < 2) begin : g_bad_stages
    $error("sadma_req_sel needs at least two sync stages");
  end

  // ---------------------------------------------------------------
  // external request pin synchroniser
  // ---------------------------------------------------------------
  logic [STAGES-1:0] ext_sync;
  logic ext_last;
  logic ext_fall;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ext_sync <= '1;
    end else begin
      ext_sync <= {ext_sync[STAGES-2:0], i_ext_req_n};
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ext_last <= 1'b1;
    end else begin
      ext_last <= ext_sync[STAGES-1];
    end
  end

  assign ext_fall = ext_last & ~ext_sync[STAGES-1];

  // ---------------------------------------------------------------
  // source mux and sticky pending flag
  // ---------------------------------------------------------------
  logic event_hit;

  always_comb begin
    unique case (i_src)
      sadma_pkg::SRC_TIMER0: event_hit = i_timer_match[0];
      sadma_pkg::SRC_TIMER1: event_hit = i_timer_match[1];
      sadma_pkg::SRC_TIMER2: event_hit = i_timer_match[2];
      sadma_pkg::SRC_TIMER3: event_hit = i_timer_match[3];
      sadma_pkg::SRC_SER_TX_EMPTY: event_hit = i_ser_tx_empty;
      sadma_pkg::SRC_SER_RX_FULL: event_hit = i_ser_rx_full;
      sadma_pkg::SRC_EXT_REQ: event_hit = ext_fall;
      default: event_hit = 1'b0;
    endcase
  end

  // a new request in the cycle of acceptance stays pending
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pending <= 1'b0;
    end else if (event_hit) begin
      o_pending <= 1'b1;
    end else if (i_take) begin
      o_pending <= 1'b0;
    end
  end

endmodule : sadma_req_sel

/* logic/sadma_channel.sv */
// Behaviour
// - I/O mode is chosen by this channel's own control register, independent of any other channel.
// - idle mode is chosen by this channel's own control register, independent of any other channel.
// - each accepted request moves exactly one byte or word, repeated until the count is done.
// - a serial receive-full request reads the I/O address and writes memory; all other sources go memory to I/O.
// - in I/O mode the 24-bit memory address steps up or down by the transfer size after each transfer.
// - the I/O address is the 8-bit low byte with the upper 16 bits forced to ones, and never steps.
// - in idle mode both addresses stay fixed for the whole run.
// - the 16-bit transfer counter decrements by one after every transfer.
// - in I/O mode reaching zero clears the channel enable, and interrupts only if the irq enable is set.
// - in idle mode reaching zero clears the channel enable, stops, and always requests an interrupt.
// - a starting count of zero gives 65,536 transfers.
// - requests come from timer match 0 to 3, serial tx-empty, serial rx-full or the external request pin.
//
// Implementation choices: the placing of the registers and strobed register access.
module sadma_channel (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // register port
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // activation sources
  input wire logic [3:0] I_TIMER_MATCH,
  input wire logic I_SER_TX_EMPTY,
  input wire logic I_SER_RX_FULL,
  input wire logic I_EXT_REQ_N,
  // system bus master
  output sadma_pkg::sadma_bus_cmd_t O_BUS,
  input wire logic I_BUS_ACK,
  input wire logic [15:0] I_BUS_RDATA,
  // interrupt
  output logic O_IRQ
);

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } sadma_state_t;

  sadma_state_t state;
  sadma_state_t next_state;
  sadma_pkg::sadma_ctrl_t ctrl;
  logic [23:0] memory_side_address;
  logic [7:0] io_side_address_low;
  logic [15:0] transfer_counter;
  logic [1:0] status;
  logic [1:0] mask;
  logic to_memory;

  logic wr_ctrl;
  logic wr_mem;
  logic wr_io;
  logic wr_count;
  logic wr_mask;
  logic rd_status;

  assign wr_ctrl = I_WR && (I_ADDR == sadma_pkg::OFS_CONTROL);
  assign wr_mem = I_WR && (I_ADDR == sadma_pkg::OFS_MEM_ADDR);
  assign wr_io = I_WR && (I_ADDR == sadma_pkg::OFS_IO_LOW);
  assign wr_count = I_WR && (I_ADDR == sadma_pkg::OFS_COUNT);
  assign wr_mask = I_WR && (I_ADDR == sadma_pkg::OFS_MASK);
  assign rd_status = I_RD && (I_ADDR == sadma_pkg::OFS_STATUS);

  // ---------------------------------------------------------------
  // elaboration checks on the shared layout
  // ---------------------------------------------------------------
  if ($bits(sadma_pkg::sadma_ctrl_t) != sadma_pkg::CONTROL_W) begin : g_bad_ctrl_w
    $error("control layout does not fill the control register width");
  end
  if ($bits(status) != sadma_pkg::STATUS_W) begin : g_bad_status_w
    $error("status register width differs from the status layout");
  end
  if (sadma_pkg::ST_IRQ_BIT >= sadma_pkg::STATUS_W) begin : g_bad_irq_pos
    $error("interrupt request bit lies outside the status register");
  end
  if (sadma_pkg::ST_END_BIT >= sadma_pkg::STATUS_W) begin : g_bad_end_pos
    $error("run end bit lies outside the status register");
  end
  if (sadma_pkg::ST_IRQ_BIT == sadma_pkg::ST_END_BIT) begin : g_st_overlap
    $error("status bits share one position");
  end
  if (sadma_pkg::STEP_BYTE == 24'h00_0000 || sadma_pkg::STEP_WORD == 24'h00_0000) begin : g_bad_step
    $error("address step of zero would hold the address in I/O mode");
  end
  if (sadma_pkg::COUNT_LAST == 16'h0000) begin : g_bad_last
    $error("last-transfer count of zero would never end a run");
  end
  if (sadma_pkg::SYNC_STAGES < 2) begin : g_bad_sync
    $error("external request pin needs at least two sync stages");
  end

  // ---------------------------------------------------------------
  // request selection
  // ---------------------------------------------------------------
  logic pending;
  logic start;
  logic read_done;
  logic write_done;
  logic last_xfer;
  logic run_end;

  // a request taken while disabled waits in pending until the enable is set
  assign start = state[0] && ctrl.channel_enable_bit && pending;
  assign read_done = state[1] && I_BUS_ACK;
  assign write_done = state[2] && I_BUS_ACK;
  assign last_xfer = transfer_counter == sadma_pkg::COUNT_LAST;
  assign run_end = write_done && last_xfer;

  sadma_req_sel #(
    .STAGES(sadma_pkg::SYNC_STAGES)
  ) u_req_sel (
    .i_clock(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_src(ctrl.src),
    .i_take(start),
    .i_timer_match(I_TIMER_MATCH),
    .i_ser_tx_empty(I_SER_TX_EMPTY),
    .i_ser_rx_full(I_SER_RX_FULL),
    .i_ext_req_n(I_EXT_REQ_N),
    .o_pending(pending)
  );

  // ---------------------------------------------------------------
  // address forming
  // ---------------------------------------------------------------
  logic [23:0] io_addr;
  logic [23:0] step;
  logic [23:0] next_mem_addr;

  assign io_addr = {sadma_pkg::IO_HIGH_ONES, io_side_address_low};
  assign step = ctrl.word_size ? sadma_pkg::STEP_WORD : sadma_pkg::STEP_BYTE;
  assign next_mem_addr = ctrl.addr_dec ? memory_side_address - step
                                       : memory_side_address + step;

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        if (I_BUS_ACK) begin
          next_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (I_BUS_ACK) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // direction is fixed at the start of each transfer
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      to_memory <= 1'b0;
    end else if (start) begin
      to_memory <= ctrl.src == sadma_pkg::SRC_SER_RX_FULL;
    end
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      O_BUS <= sadma_pkg::BUS_IDLE;
    end else if (start) begin
      O_BUS.valid <= 1'b1;
      O_BUS.write <= 1'b0;
      O_BUS.word <= ctrl.word_size;
      if (ctrl.src == sadma_pkg::SRC_SER_RX_FULL) begin
        O_BUS.addr <= io_addr;
      end else begin
        O_BUS.addr <= memory_side_address;
      end
    end else if (read_done) begin
      O_BUS.write <= 1'b1;
      O_BUS.wdata <= I_BUS_RDATA;
      if (to_memory) begin
        O_BUS.addr <= memory_side_address;
      end else begin
        O_BUS.addr <= io_addr;
      end
    end else if (write_done) begin
      O_BUS.valid <= 1'b0;
      O_BUS.write <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // a software write wins over the hardware clear of the enable
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      ctrl <= sadma_pkg::CONTROL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= sadma_pkg::sadma_ctrl_t'(I_WDATA[sadma_pkg::CONTROL_W-1:0]);
    end else if (run_end) begin
      ctrl.channel_enable_bit <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // memory and I/O address registers
  // ---------------------------------------------------------------
  // software writes win over the hardware step
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      memory_side_address <= sadma_pkg::MEM_ADDR_RESET;
    end else if (wr_mem) begin
      memory_side_address <= I_WDATA[23:0];
    end else if (write_done && !ctrl.idle_mode) begin
      memory_side_address <= next_mem_addr;
    end
  end

  // the I/O side low byte is only ever written by software
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      io_side_address_low <= sadma_pkg::IO_LOW_RESET;
    end else if (wr_io) begin
      io_side_address_low <= I_WDATA[7:0];
    end
  end

  // ---------------------------------------------------------------
  // transfer counter
  // ---------------------------------------------------------------
  // zero wraps to all ones, so a zero start runs the full range
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      transfer_counter <= sadma_pkg::COUNT_RESET;
    end else if (wr_count) begin
      transfer_counter <= I_WDATA[15:0];
    end else if (write_done) begin
      transfer_counter <= transfer_counter - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // status, mask and interrupt
  // ---------------------------------------------------------------
  logic [1:0] status_set;
  logic irq_wanted;

  // run end is always flagged; the interrupt request only where the mode asks for it
  assign irq_wanted = ctrl.idle_mode || ctrl.completion_irq_enable;

  always_comb begin
    status_set = '0;
    status_set[sadma_pkg::ST_END_BIT] = run_end;
    status_set[sadma_pkg::ST_IRQ_BIT] = run_end && irq_wanted;
  end

  // a set in the cycle of the clearing read survives
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      status <= '0;
    end else if (rd_status) begin
      status <= status_set;
    end else begin
      status <= status | status_set;
    end
  end

  // the mask has the layout of the status register
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      mask <= sadma_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask <= I_WDATA[sadma_pkg::STATUS_W-1:0];
    end
  end

  // level output, one cycle behind the status and mask it follows
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(status & mask);
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (I_RD) begin
      unique case (I_ADDR)
        sadma_pkg::OFS_CONTROL: next_rdata = {24'h00_0000, ctrl};
        sadma_pkg::OFS_MEM_ADDR: next_rdata = {8'h00, memory_side_address};
        sadma_pkg::OFS_IO_LOW: next_rdata = {24'h00_0000, io_side_address_low};
        sadma_pkg::OFS_COUNT: next_rdata = {16'h0000, transfer_counter};
        sadma_pkg::OFS_STATUS: next_rdata = {30'h0000_0000, status};
        sadma_pkg::OFS_MASK: next_rdata = {30'h0000_0000, mask};
        sadma_pkg::OFS_STATE: next_rdata = {28'h000_0000, pending, state};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read data stands for one cycle only and is zero otherwise
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      O_RDATA <= '0;
    end else begin
      O_RDATA <= next_rdata;
    end
  end

endmodule : sadma_channel

/* verification/sadma_channel_properties.sv */
module sadma_chk (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // register port
  input wire logic [3:0] I_ADDR,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  // bus and interrupt
  input wire sadma_pkg::sadma_bus_cmd_t O_BUS,
  input wire logic I_BUS_ACK,
  input wire logic [15:0] I_BUS_RDATA,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);
  logic rd_ack;
  logic wr_ack;
  logic mask_wr;
  assign rd_ack = O_BUS.valid && !O_BUS.write && I_BUS_ACK;
  assign wr_ack = O_BUS.valid && O_BUS.write && I_BUS_ACK;
  assign mask_wr = I_WR && I_ADDR == sadma_pkg::OFS_MASK;
  // ---------------------------------------------------------------
  // bus cycle sequence
  // ---------------------------------------------------------------
  property p_read_first;
    $rose(O_BUS.valid) |-> !O_BUS.write;
  endproperty
  a_read_first: assert property (p_read_first) else $error("transfer began with a write");
  property p_forward;
    rd_ack |=> O_BUS.valid && O_BUS.write && O_BUS.wdata == $past(I_BUS_RDATA) && O_BUS.word == $past(O_BUS.word);
  endproperty
  a_forward: assert property (p_forward) else $error("write did not carry read data");
  property p_one_pair;
    wr_ack |=> !O_BUS.valid;
  endproperty
  a_one_pair: assert property (p_one_pair) else $error("bus busy after write");
  property p_stand;
    O_BUS.valid && !I_BUS_ACK |=> $stable(O_BUS);
  endproperty
  a_stand: assert property (p_stand) else $error("command changed before ack");
  property p_io_side;
    rd_ack && O_BUS.addr[23:8] != 16'hFFFF |=> O_BUS.addr[23:8] == 16'hFFFF;
  endproperty
  a_io_side: assert property (p_io_side) else $error("no fixed io address in pair");
  // ---------------------------------------------------------------
  // interrupt and read port
  // ---------------------------------------------------------------
  property p_irq_rise;
    $rose(O_IRQ) |-> $past(wr_ack, 2) || $past(mask_wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without run end");
  property p_irq_fall;
    $fell(O_IRQ) |-> $past(I_RD && I_ADDR == sadma_pkg::OFS_STATUS, 2) || $past(mask_wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
  property p_rdata_zero;
    !I_RD |=> O_RDATA == 32'h0000_0000;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside read slot");
endmodule : sadma_chk

bind sadma_channel sadma_chk chk (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_BUS(O_BUS), .I_BUS_ACK(I_BUS_ACK), .I_BUS_RDATA(I_BUS_RDATA), .O_IRQ(O_IRQ)
);

/* verification/sadma_bus_model.sv */
module sadma_bus_model (
  // clock, reset and pace
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_slow,
  // bus
  input wire sadma_pkg::sadma_bus_cmd_t i_bus,
  output logic o_ack,
  output logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;
  logic [15:0] mem_val;
  // every location reads as a pattern of its own address
  assign mem_val = i_bus.addr[15:0] ^ 16'hA5A5;
  assign o_rdata = o_ack ? mem_val : ~mem_val;
  always_ff @(posedge i_clock) begin
    o_ack <= 1'b0;
    if (!i_rst_n) begin
      wait_cnt <= 2'h3;
    end else if (i_bus.valid && !o_ack) begin
      if (!i_slow || wait_cnt == 2'h0) begin
        o_ack <= 1'b1;
        wait_cnt <= 2'h3;
      end else begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule : sadma_bus_model

/* verification/test_sadma_channel.sv */
module test_sadma_channel;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic idle, word, dec, irqen, irq;
    logic [15:0] cnt;
  } sadma_row_t;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0, rd = 1'b0, tx = 1'b0, rx = 1'b0, ext_n = 1'b1, slow = 1'b0;
  logic [3:0] tmr = 4'h0;
  logic [31:0] rdata;
  logic ack, irq;
  logic [15:0] brd;
  logic [23:0] m;
  sadma_pkg::sadma_bus_cmd_t bus;
  sadma_pkg::sadma_bus_cmd_t wq[$];
  int num_errors = 0;
  int compares = 0;
  sadma_row_t rows[7] = '{'{0, 0, 0, 1, 1, 3}, '{0, 1, 1, 0, 0, 2}, '{1, 0, 0, 0, 1, 2},
    '{1, 1, 0, 1, 1, 2}, '{0, 1, 0, 1, 1, 2}, '{0, 0, 1, 0, 0, 3}, '{1, 0, 1, 0, 1, 2}};
  always #5 clock = ~clock;
  sadma_channel dut (.I_CLOCK(clock), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_TIMER_MATCH(tmr), .I_SER_TX_EMPTY(tx), .I_SER_RX_FULL(rx),
    .I_EXT_REQ_N(ext_n), .O_BUS(bus), .I_BUS_ACK(ack), .I_BUS_RDATA(brd), .O_IRQ(irq));
  sadma_bus_model bus_model (.i_clock(clock), .i_rst_n(rst_n), .i_slow(slow), .i_bus(bus), .o_ack(ack),
    .o_rdata(brd));
  always @(posedge clock) if (bus.valid && bus.write && ack) wq.push_back(bus);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask : rd_chk
  task automatic pulse(input sadma_pkg::sadma_src_t s);
    @(posedge clock);
    tmr <= (s < sadma_pkg::SRC_SER_TX_EMPTY) ? 4'h1 << s : 4'h0;
    tx <= s == sadma_pkg::SRC_SER_TX_EMPTY;
    rx <= s == sadma_pkg::SRC_SER_RX_FULL;
    ext_n <= s != sadma_pkg::SRC_EXT_REQ;
    @(posedge clock);
    tmr <= 4'h0;
    tx <= 1'b0;
    rx <= 1'b0;
    repeat (2) @(posedge clock);
    ext_n <= 1'b1;
  endtask : pulse
  function automatic logic [31:0] ctrl_of(input sadma_pkg::sadma_src_t s, input sadma_row_t r, input logic en);
    return {24'h00_0000, s, r.dec, r.word, r.idle, r.irqen, en};
  endfunction : ctrl_of
  task automatic run(input sadma_pkg::sadma_src_t s, input sadma_row_t r, input logic [23:0] m0,
      input logic [7:0] io, input logic [1:0] mask, input int n, output logic [23:0] ma);
    sadma_pkg::sadma_bus_cmd_t b;
    logic [23:0] io_a, step;
    logic rx_dir;
    int w;
    io_a = {sadma_pkg::IO_HIGH_ONES, io};
    step = r.word ? sadma_pkg::STEP_WORD : sadma_pkg::STEP_BYTE;
    rx_dir = s == sadma_pkg::SRC_SER_RX_FULL;
    ma = m0;
    wr_reg(sadma_pkg::OFS_MEM_ADDR, {8'h00, m0});
    wr_reg(sadma_pkg::OFS_IO_LOW, {24'h00_0000, io});
    wr_reg(sadma_pkg::OFS_COUNT, {16'h0000, r.cnt});
    wr_reg(sadma_pkg::OFS_MASK, {30'h0000_0000, mask});
    wr_reg(sadma_pkg::OFS_CONTROL, ctrl_of(s, r, 1'b1));
    for (int k = 0; k < n; k++) begin
      pulse(s);
      w = 0;
      while (wq.size() == 0 && w < 60) begin
        @(posedge clock);
        w++;
      end
      b = (wq.size() == 0) ? sadma_pkg::BUS_IDLE : wq.pop_front();
      check("dest", b.addr, rx_dir ? ma : io_a);
      check("data", b.wdata, (rx_dir ? io_a[15:0] : ma[15:0]) ^ 16'hA5A5);
      check("size", b.word, r.word);
      if (!r.idle) ma = r.dec ? ma - step : ma + step;
    end
    repeat (4) @(posedge clock);
  endtask : run
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    wr_reg(sadma_pkg::OFS_STATUS, 32'h0000_0003);
    wr_reg(4'hF, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset", (i == 7) ? 4'hF : 4'(i), (i == 0) ? 32'h0000_00E0 : (i == 6) ? 32'h0000_0001 : 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      slow <= i[0];
      run(sadma_pkg::sadma_src_t'(i), rows[i], 24'h12_3440 + 24'(i) * 24'h00_0100, 8'h80 | 8'(i), 2'h1,
        int'(rows[i].cnt), m);
      check("irq", irq, rows[i].irq);
      rd_chk("count", sadma_pkg::OFS_COUNT, 32'h0);
      rd_chk("control", sadma_pkg::OFS_CONTROL, ctrl_of(sadma_pkg::sadma_src_t'(i), rows[i], 1'b0));
      rd_chk("mem", sadma_pkg::OFS_MEM_ADDR, {8'h00, m});
      rd_chk("status", sadma_pkg::OFS_STATUS, {30'h0, 1'b1, rows[i].irq});
      rd_chk("status", sadma_pkg::OFS_STATUS, 32'h0);
      check("irq", irq, 1'b0);
      $display("test row %0d done", i);
    end
    run(sadma_pkg::SRC_TIMER0, '{0, 0, 0, 1, 1, 0}, 24'h00_1000, 8'h10, 2'h3, 1, m);
    rd_chk("count", sadma_pkg::OFS_COUNT, 32'h0000_FFFF);
    rd_chk("control", sadma_pkg::OFS_CONTROL, 32'h0000_0003);
    pulse(sadma_pkg::SRC_TIMER1);
    repeat (10) @(posedge clock);
    check("unselected", wq.size(), 0);
    wr_reg(sadma_pkg::OFS_CONTROL, 32'h0000_0002);
    $display("test zero count done");
    run(sadma_pkg::SRC_TIMER2, '{0, 0, 0, 1, 1, 1}, 24'h00_2000, 8'h20, 2'h0, 1, m);
    check("masked", irq, 1'b0);
    wr_reg(sadma_pkg::OFS_MASK, 32'h0000_0001);
    repeat (2) @(posedge clock);
    #1;
    check("unmasked", irq, 1'b1);
    pulse(sadma_pkg::SRC_TIMER2);
    repeat (10) @(posedge clock);
    check("stopped", wq.size(), 0);
    $display("test mask done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk("reset", sadma_pkg::OFS_CONTROL, 32'h0000_00E0);
    rd_chk("reset", sadma_pkg::OFS_STATE, 32'h0000_0001);
    check("irq", irq, 1'b0);
    $display("test second reset done");
    end_of_test();
  end
endmodule : test_sadma_channel
